// ### hdl/ssi_pin_mux.sv
// secondary interface pin mux, startup loader and configuration registers
// ----------------------------------------
// What this block does
// - logic clock loop reference is the on-chip oscillator by default.
// - host can select external clock on pin C as loop reference.
// - external reference allowed only with pulse-width or short-pulse-code output.
// - exactly one secondary interface drives the three pins beside the serial port.
// - secondary interface runs from fused defaults with no host transaction.
// - at startup fuses load configuration registers; all but the calibration word may then be overwritten.
// - pin A outputs phase A, hall 1, pulse-width or code; input for trigger.
// - pin B outputs only phase B or hall 2.
// - pin C is external clock in, index out or hall 3 out.
// - one drive-mode bit sets push-pull or open-drain for all three pins.
// - serial data pin push-pull by default, open-drain by mode bit.
// - serial bytes checked by 8-bit CRC, code frames by 4-bit nibble.
// - startup runs built-in self-test before the interface goes live.
// - host can enable converter test vectors, stream invert or combine.
// - host talks over serial clock, select and one shared data line.
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "ssi_defs.svh"

module ssi_pin_mux #(
	parameter logic [7:0] CRC8_POLY = 8'h1d,
	parameter logic [3:0] CRC4_POLY = 4'h3,
	parameter int BIST_TIMEOUT_US = `SSI_BIST_TIMEOUT_US
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// fused defaults
	input wire logic [15:0] fuse_mode3,
	input wire logic [15:0] fuse_interface_ab_config,
	input wire logic [15:0] fuse_cal,
	// configuration access from the serial port engine
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [7:0] cfg_addr,
	input wire logic [15:0] cfg_wdata,
	output logic [15:0] cfg_rdata,
	// serial data pin and its check
	input wire logic ser_tx_data,
	input wire logic ser_tx_en,
	input wire logic ser_crc_clr,
	input wire logic ser_byte_valid,
	input wire logic [7:0] ser_byte,
	output logic serial_data_o,
	output logic serial_data_oe_n,
	output logic [7:0] ser_crc,
	// secondary protocol sources
	input wire logic pwm_src,
	input wire logic spc_src,
	input wire logic enc_phase_a,
	input wire logic enc_phase_b,
	input wire logic encoder_index,
	input wire logic hall_signal_one,
	input wire logic hall_signal_two,
	input wire logic hall_signal_three,
	// short pulse code nibble check
	input wire logic spc_frame_start,
	input wire logic spc_nib_valid,
	input wire logic [3:0] spc_nib,
	output logic [3:0] spc_crc,
	// interface pins
	input wire logic iface_pin_a_i,
	output logic iface_pin_a_o,
	output logic iface_pin_a_oe_n,
	output logic iface_pin_b_o,
	output logic iface_pin_b_oe_n,
	input wire logic iface_pin_c_i,
	output logic iface_pin_c_o,
	output logic iface_pin_c_oe_n,
	// clock reference and trigger
	output logic pll_ref_ext,
	output logic ext_ref_clk,
	output logic spc_trigger,
	// self-test and test paths
	output logic bist_start,
	input wire logic bist_done,
	input wire logic bist_pass,
	output logic bist_fail,
	output logic startup_done,
	output logic [15:0] cal_word,
	output logic test_vec_en,
	output logic stream_invert,
	output logic stream_combine
);

	// ----------------------------------------
	// constants and checks
	// ----------------------------------------
	localparam int BIST_CYC_RAW = BIST_TIMEOUT_US * `SSI_CLK_MHZ;
	localparam int BIST_CYC = (BIST_CYC_RAW < 1) ? 1 : BIST_CYC_RAW;
	localparam int BIST_CNT_W = $clog2(BIST_CYC + 1);

	// refuse a timeout under 1 us or beyond 4096 cycles
	if (BIST_TIMEOUT_US < 1 || BIST_CYC > 4096) begin : g_bad_timeout
		$error("ssi_pin_mux: self-test timeout out of range");
	end

	// ----------------------------------------
	// startup sequence
	// ----------------------------------------
	ssi_pkg::ssi_state_e state_q;
	logic [BIST_CNT_W-1:0] bist_cnt_q;
	logic bist_start_q;
	logic bist_fail_q;
	logic run;
	logic run_q;

	assign run = (state_q == ssi_pkg::SSI_ST_RUN);

	// fuses land one cycle after reset release, then self-test
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_q <= ssi_pkg::SSI_ST_FUSE;
		end else begin
			unique case (state_q)
				ssi_pkg::SSI_ST_FUSE: begin
					state_q <= ssi_pkg::SSI_ST_BIST;
				end
				ssi_pkg::SSI_ST_BIST: begin
					if (bist_done || bist_cnt_q == BIST_CNT_W'(BIST_CYC)) begin
						state_q <= ssi_pkg::SSI_ST_RUN;
					end
				end
				ssi_pkg::SSI_ST_RUN: begin
					state_q <= ssi_pkg::SSI_ST_RUN;
				end
				default: begin
					state_q <= ssi_pkg::SSI_ST_FUSE;
				end
			endcase
		end
	end

	// a hung self-test must not keep the interface off forever
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bist_cnt_q <= '0;
			bist_start_q <= 1'b0;
			bist_fail_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			bist_start_q <= (state_q == ssi_pkg::SSI_ST_FUSE);
			// registered copy of the run state for the output pin
			if (state_q == ssi_pkg::SSI_ST_BIST && (bist_done || bist_cnt_q == BIST_CNT_W'(BIST_CYC))) begin
				run_q <= 1'b1;
			end
			if (state_q == ssi_pkg::SSI_ST_BIST) begin
				bist_cnt_q <= bist_cnt_q + BIST_CNT_W'(1);
				if (bist_done) begin
					bist_fail_q <= ~bist_pass;
				end else if (bist_cnt_q == BIST_CNT_W'(BIST_CYC)) begin
					bist_fail_q <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic [15:0] mode3_q;
	logic [15:0] interface_ab_config_q;
	logic [15:0] cal_q;
	logic [15:0] rdata_q;

	// copied from fuses, afterwards mode3 and interface_ab_config writable by the host
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			mode3_q <= `SSI_REG_ZERO;
			interface_ab_config_q <= `SSI_REG_ZERO;
			cal_q <= `SSI_REG_ZERO;
		end else if (state_q == ssi_pkg::SSI_ST_FUSE) begin
			mode3_q <= fuse_mode3;
			interface_ab_config_q <= fuse_interface_ab_config;
			cal_q <= fuse_cal;
		end else if (cfg_wr_en) begin
			if (cfg_addr == `SSI_ADDR_MODE3) begin
				mode3_q <= cfg_wdata;
			end
			if (cfg_addr == `SSI_ADDR_INTERFACE_AB_CONFIG) begin
				interface_ab_config_q <= cfg_wdata;
			end
		end
	end

	// unmapped addresses read zero
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdata_q <= `SSI_REG_ZERO;
		end else if (cfg_rd_en) begin
			unique case (cfg_addr)
				`SSI_ADDR_MODE3: rdata_q <= mode3_q;
				`SSI_ADDR_INTERFACE_AB_CONFIG: rdata_q <= interface_ab_config_q;
				default: rdata_q <= `SSI_REG_ZERO;
			endcase
		end
	end

	// ----------------------------------------
	// mode decode and clock reference
	// ----------------------------------------
	ssi_pkg::ssi_mode_t mode;
	logic iface_od;
	logic ext_ok;
	logic pll_ref_ext_q;
	logic test_vec_q;
	logic invert_q;
	logic combine_q;

	assign mode = interface_ab_config_q[`SSI_INTERFACE_AB_CONFIG_MODE_HI:`SSI_INTERFACE_AB_CONFIG_MODE_LO];
	assign iface_od = interface_ab_config_q[`SSI_IFACE_OPEN_DRAIN_SEL];
	assign ext_ok = (mode == `SSI_IF_PWM) || (mode == `SSI_IF_SPC);

	// oscillator stays the reference unless the mode allows otherwise
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pll_ref_ext_q <= 1'b0;
		end else begin
			pll_ref_ext_q <= interface_ab_config_q[`SSI_INTERFACE_AB_CONFIG_EXTCLK] & ext_ok;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			test_vec_q <= 1'b0;
			invert_q <= 1'b0;
			combine_q <= 1'b0;
		end else begin
			test_vec_q <= run & mode3_q[`SSI_MODE3_TESTVEC];
			invert_q <= run & mode3_q[`SSI_MODE3_INVERT];
			combine_q <= run & mode3_q[`SSI_MODE3_COMBINE];
		end
	end

	// ----------------------------------------
	// pin routing
	// ----------------------------------------
	logic a_data;
	logic a_en;
	logic b_data;
	logic b_en;
	logic c_data;
	logic c_en;

	// pins stay released until fuses and self-test are done
	always_comb begin
		a_data = 1'b0;
		b_data = 1'b0;
		c_data = 1'b0;
		a_en = 1'b0;
		b_en = 1'b0;
		c_en = 1'b0;
		unique case (mode)
			`SSI_IF_PWM: begin
				a_data = pwm_src;
				a_en = run;
			end
			`SSI_IF_ENC: begin
				a_data = enc_phase_a;
				b_data = enc_phase_b;
				c_data = encoder_index;
				a_en = run;
				b_en = run;
				c_en = run;
			end
			`SSI_IF_HALL: begin
				a_data = hall_signal_one;
				b_data = hall_signal_two;
				c_data = hall_signal_three;
				a_en = run;
				b_en = run;
				c_en = run;
			end
			`SSI_IF_SPC: begin
				a_data = spc_src;
				a_en = run;
			end
		endcase
	end

	ssi_pad u_pad_a (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.data(a_data),
		.drive_en(a_en),
		.open_drain(iface_od),
		.pin_o(iface_pin_a_o),
		.pin_oe_n(iface_pin_a_oe_n)
	);

	ssi_pad u_pad_b (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.data(b_data),
		.drive_en(b_en),
		.open_drain(iface_od),
		.pin_o(iface_pin_b_o),
		.pin_oe_n(iface_pin_b_oe_n)
	);

	ssi_pad u_pad_c (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.data(c_data),
		.drive_en(c_en),
		.open_drain(iface_od),
		.pin_o(iface_pin_c_o),
		.pin_oe_n(iface_pin_c_oe_n)
	);

	// host owns the line framing; only drive mode lives here
	ssi_pad u_pad_ser (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.data(ser_tx_data),
		.drive_en(ser_tx_en),
		.open_drain(mode3_q[`SSI_MODE3_SER_OD]),
		.pin_o(serial_data_o),
		.pin_oe_n(serial_data_oe_n)
	);

	// ----------------------------------------
	// pin inputs
	// ----------------------------------------
	logic pin_a_lvl;
	logic pin_c_lvl;
	logic pin_a_prev_q;
	logic trig_q;
	logic ext_clk_q;

	ssi_sync u_sync_a (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.async_in(iface_pin_a_i),
		.level_out(pin_a_lvl)
	);

	ssi_sync u_sync_c (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.async_in(iface_pin_c_i),
		.level_out(pin_c_lvl)
	);

	// trigger is a falling edge pulled by the master on pin A
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pin_a_prev_q <= 1'b1;
			trig_q <= 1'b0;
			ext_clk_q <= 1'b0;
		end else begin
			pin_a_prev_q <= pin_a_lvl;
			trig_q <= run & (mode == `SSI_IF_SPC) & pin_a_prev_q & ~pin_a_lvl;
			ext_clk_q <= pll_ref_ext_q & pin_c_lvl;
		end
	end

	// ----------------------------------------
	// transfer checks
	// ----------------------------------------
	function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] dat);
		logic [7:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			c = (c[7] ^ dat[i]) ? ((c << 1) ^ CRC8_POLY) : (c << 1);
		end
		return c;
	endfunction

	function automatic logic [3:0] crc4_nib(input logic [3:0] crc, input logic [3:0] dat);
		logic [3:0] c;
		c = crc;
		for (int i = 3; i >= 0; i--) begin
			c = (c[3] ^ dat[i]) ? ((c << 1) ^ CRC4_POLY) : (c << 1);
		end
		return c;
	endfunction

	logic [7:0] ser_crc_q;
	logic [3:0] spc_crc_q;

	always_ff @(posedge clk_sys) begin
		if (!rstn || ser_crc_clr) begin
			ser_crc_q <= `SSI_CRC8_SEED;
		end else if (ser_byte_valid) begin
			ser_crc_q <= crc8_byte(ser_crc_q, ser_byte);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn || spc_frame_start) begin
			spc_crc_q <= `SSI_CRC4_SEED;
		end else if (spc_nib_valid) begin
			spc_crc_q <= crc4_nib(spc_crc_q, spc_nib);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign cfg_rdata = rdata_q;
	assign ser_crc = ser_crc_q;
	assign spc_crc = spc_crc_q;
	assign pll_ref_ext = pll_ref_ext_q;
	assign ext_ref_clk = ext_clk_q;
	assign spc_trigger = trig_q;
	assign bist_start = bist_start_q;
	assign bist_fail = bist_fail_q;
	assign startup_done = run_q;
	assign cal_word = cal_q;
	assign test_vec_en = test_vec_q;
	assign stream_invert = invert_q;
	assign stream_combine = combine_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_ref_osc;
		interface_ab_config_q[`SSI_INTERFACE_AB_CONFIG_EXTCLK] && !ext_ok |=> !pll_ref_ext_q;
	endproperty
	a_ref_osc: assert property (p_ref_osc) else $error("external reference taken in encoder or hall mode");

	property p_ref_ext;
		interface_ab_config_q[`SSI_INTERFACE_AB_CONFIG_EXTCLK] && ext_ok |=> pll_ref_ext_q;
	endproperty
	a_ref_ext: assert property (p_ref_ext) else $error("external reference request not honoured");

	property p_pin_c_free;
		pll_ref_ext_q |-> iface_pin_c_oe_n;
	endproperty
	a_pin_c_free: assert property (p_pin_c_free) else $error("pin C driven while used as clock input");

	property p_hall_b;
		run && mode == `SSI_IF_HALL && !iface_od |=> !iface_pin_b_oe_n && iface_pin_b_o == $past(hall_signal_two);
	endproperty
	a_hall_b: assert property (p_hall_b) else $error("pin B does not carry hall signal two");

	property p_single_if;
		run && (mode == `SSI_IF_PWM || mode == `SSI_IF_SPC) |=> iface_pin_b_oe_n;
	endproperty
	a_single_if: assert property (p_single_if) else $error("pin B driven outside encoder or hall mode");

	property p_iface_od;
		iface_od |=> !iface_pin_a_o && !iface_pin_b_o && !iface_pin_c_o;
	endproperty
	a_iface_od: assert property (p_iface_od) else $error("open-drain pin driven high");

	property p_ser_pp;
		!mode3_q[`SSI_MODE3_SER_OD] && ser_tx_en |=> !serial_data_oe_n && serial_data_o == $past(ser_tx_data);
	endproperty
	a_ser_pp: assert property (p_ser_pp) else $error("serial data not driven push-pull");

	property p_fuse_load;
		state_q == ssi_pkg::SSI_ST_FUSE |=> interface_ab_config_q == $past(fuse_interface_ab_config) && mode3_q == $past(fuse_mode3);
	endproperty
	a_fuse_load: assert property (p_fuse_load) else $error("fuse defaults not loaded");

	property p_bist_seq;
		state_q == ssi_pkg::SSI_ST_FUSE |=> bist_start_q ##1 !bist_start_q;
	endproperty
	a_bist_seq: assert property (p_bist_seq) else $error("self-test start not a single pulse");

	property p_pins_quiet;
		!run |=> iface_pin_a_oe_n;
	endproperty
	a_pins_quiet: assert property (p_pins_quiet) else $error("pin A driven before startup finished");

	property p_crc4_seed;
		spc_frame_start |=> spc_crc_q == `SSI_CRC4_SEED;
	endproperty
	a_crc4_seed: assert property (p_crc4_seed) else $error("nibble check not reseeded");

	property p_test_vec;
		run && cfg_wr_en && cfg_addr == `SSI_ADDR_MODE3 && cfg_wdata[`SSI_MODE3_TESTVEC] |=> ##1 test_vec_q;
	endproperty
	a_test_vec: assert property (p_test_vec) else $error("test vectors not enabled");

	c_hall_run: cover property (run && mode == `SSI_IF_HALL);
	c_ext_ref: cover property (pll_ref_ext_q && run);
	c_trigger: cover property (trig_q);

endmodule // ssi_pin_mux

`default_nettype wire

// ### hdl/ssi_defs.svh
// register offsets, field positions, codes and timing for the secondary interface pin mux
`ifndef SSI_DEFS_SVH
`define SSI_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SSI_ADDR_W 8
`define SSI_REG_W 16
`define SSI_ADDR_MODE3 8'h09
`define SSI_ADDR_INTERFACE_AB_CONFIG 8'h0d
`define SSI_REG_ZERO 16'h0000

// ----------------------------------------
// interface_ab_config fields
// ----------------------------------------
`define SSI_INTERFACE_AB_CONFIG_MODE_LO 0
`define SSI_INTERFACE_AB_CONFIG_MODE_HI 1
`define SSI_IFACE_OPEN_DRAIN_SEL 2
`define SSI_INTERFACE_AB_CONFIG_EXTCLK 3

// ----------------------------------------
// mode_config_three fields
// ----------------------------------------
`define SSI_MODE3_SER_OD 0
`define SSI_MODE3_TESTVEC 1
`define SSI_MODE3_INVERT 2
`define SSI_MODE3_COMBINE 3

// ----------------------------------------
// secondary interface codes
// ----------------------------------------
`define SSI_IF_PWM 2'h0
`define SSI_IF_ENC 2'h1
`define SSI_IF_HALL 2'h2
`define SSI_IF_SPC 2'h3

// ----------------------------------------
// check values and timing
// ----------------------------------------
`define SSI_CRC8_SEED 8'hff
`define SSI_CRC4_SEED 4'h5
`define SSI_CLK_MHZ 10
`define SSI_BIST_TIMEOUT_US 100

`endif

// ### hdl/ssi_pkg.sv
// types shared by the secondary interface pin mux
package ssi_pkg;

	// ----------------------------------------
	// startup sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {
		SSI_ST_FUSE,
		SSI_ST_BIST,
		SSI_ST_RUN
	} ssi_state_e;

	typedef logic [1:0] ssi_mode_t;

endpackage

// ### hdl/ssi_sync.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module ssi_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// asynchronous level in, filtered level out
	input wire logic async_in,
	output logic level_out
);

	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			level_q <= 1'b0;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end

	assign level_out = level_q;

endmodule // ssi_sync

`default_nettype wire

// ### hdl/ssi_pad.sv
// registered pad driver, push-pull or open-drain
`timescale 1ns/1ps
`default_nettype none

module ssi_pad (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// drive request
	input wire logic data,
	input wire logic drive_en,
	input wire logic open_drain,
	// pad
	output logic pin_o,
	output logic pin_oe_n
);

	logic pin_q;
	logic oe_n_q;

	// open drain only pulls low; a high is left to the pull-up
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pin_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else if (open_drain) begin
			pin_q <= 1'b0;
			oe_n_q <= ~(drive_en & ~data);
		end else begin
			pin_q <= data;
			oe_n_q <= ~drive_en;
		end
	end

	assign pin_o = pin_q;
	assign pin_oe_n = oe_n_q;

endmodule // ssi_pad

`default_nettype wire

// ### sim/ssi_host_model.sv
// host controller model on the configuration port and shared serial data line
`timescale 1ns/1ps
`default_nettype none

module ssi_host_model (
	// clock
	input wire logic clk_sys,
	// configuration access
	output logic cfg_wr_en,
	output logic cfg_rd_en,
	output logic [7:0] cfg_addr,
	output logic [15:0] cfg_wdata,
	input wire logic [15:0] cfg_rdata,
	// shared serial data line
	input wire logic serial_data_o,
	input wire logic serial_data_oe_n,
	output logic data_line
);
	// ----------------------------------------
	// line resolution
	// ----------------------------------------
	// released line is pulled high, never left at the last value
	assign data_line = serial_data_oe_n ? 1'b1 : serial_data_o;

	initial begin
		cfg_wr_en = 1'b0;
		cfg_rd_en = 1'b0;
		cfg_addr = 8'h00;
		cfg_wdata = 16'h0000;
	end

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr_en = 1'b1;
		@(negedge clk_sys);
		cfg_wr_en = 1'b0;
		// scramble idle bus so a late capture shows
		cfg_addr = ~a;
		cfg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk_sys);
		cfg_addr = a;
		cfg_rd_en = 1'b1;
		@(negedge clk_sys);
		cfg_rd_en = 1'b0;
		cfg_addr = ~a;
		@(negedge clk_sys);
		d = cfg_rdata;
	endtask
endmodule // ssi_host_model
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the secondary interface pin mux
`timescale 1ns/1ps
`default_nettype none
`include "ssi_defs.svh"

module tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk_sys, rstn, cfg_wr_en, cfg_rd_en, data_line;
	logic [15:0] fuse_mode3, fuse_interface_ab_config, fuse_cal, cfg_wdata, cfg_rdata, cal_word, v;
	logic [7:0] cfg_addr, ser_byte, ser_crc;
	logic ser_tx_data, ser_tx_en, ser_crc_clr, ser_byte_valid, serial_data_o, serial_data_oe_n;
	logic pwm_src, spc_src, enc_phase_a, enc_phase_b, encoder_index;
	logic hall_signal_one, hall_signal_two, hall_signal_three;
	logic spc_frame_start, spc_nib_valid;
	logic [3:0] spc_nib, spc_crc;
	logic iface_pin_a_i, iface_pin_a_o, iface_pin_a_oe_n, iface_pin_b_o, iface_pin_b_oe_n;
	logic iface_pin_c_i, iface_pin_c_o, iface_pin_c_oe_n;
	logic pll_ref_ext, ext_ref_clk, spc_trigger, bist_start, bist_done, bist_pass, bist_fail;
	logic startup_done, test_vec_en, stream_invert, stream_combine;
	int n_fail, n_checks;

	// short self-test timeout keeps the run brief
	ssi_pin_mux #(.BIST_TIMEOUT_US(1)) i_dut (.clk_sys, .rstn, .fuse_mode3, .fuse_interface_ab_config, .fuse_cal,
		.cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wdata, .cfg_rdata, .ser_tx_data, .ser_tx_en,
		.ser_crc_clr, .ser_byte_valid, .ser_byte, .serial_data_o, .serial_data_oe_n, .ser_crc,
		.pwm_src, .spc_src, .enc_phase_a, .enc_phase_b, .encoder_index, .hall_signal_one,
		.hall_signal_two, .hall_signal_three, .spc_frame_start, .spc_nib_valid, .spc_nib, .spc_crc,
		.iface_pin_a_i, .iface_pin_a_o, .iface_pin_a_oe_n, .iface_pin_b_o, .iface_pin_b_oe_n,
		.iface_pin_c_i, .iface_pin_c_o, .iface_pin_c_oe_n, .pll_ref_ext, .ext_ref_clk, .spc_trigger,
		.bist_start, .bist_done, .bist_pass, .bist_fail, .startup_done, .cal_word, .test_vec_en,
		.stream_invert, .stream_combine);

	ssi_host_model i_host (.clk_sys, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wdata, .cfg_rdata,
		.serial_data_o, .serial_data_oe_n, .data_line);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [15:0] pins();
		return {10'h000, iface_pin_a_o, iface_pin_a_oe_n, iface_pin_b_o, iface_pin_b_oe_n,
			iface_pin_c_o, iface_pin_c_oe_n};
	endfunction

	function automatic logic mon_bit(input int idx);
		logic [3:0] m;
		m = {spc_trigger, ext_ref_clk, startup_done, bist_start};
		return m[idx];
	endfunction

	// bounded wait, fails if the level never arrives
	task automatic wait_bit(input string what, input int idx, input logic lv, input int lim);
		int k;
		k = 0;
		while (mon_bit(idx) !== lv && k < lim) begin
			@(negedge clk_sys);
			k++;
		end
		chk(what, {15'h0000, lv}, {15'h0000, mon_bit(idx)});
	endtask

	task automatic cfg(input logic [7:0] a, input logic [15:0] d);
		i_host.wr(a, d);
		step(3);
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
		i_host.rd(a, v);
		chk(what, exp, v);
	endtask

	task automatic do_reset();
		rstn = 1'b0;
		step(5);
		chk("reset pins", 16'h0015, pins());
		chk("reset crc", 16'h05ff, {4'h0, spc_crc, ser_crc});
		rstn = 1'b1;
	endtask

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h1d : 8'h00);
		return c;
	endfunction

	function automatic logic [3:0] crc4(input logic [3:0] c, input logic [3:0] b);
		for (int i = 3; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ b[i]) ? 4'h3 : 4'h0);
		return c;
	endfunction

	task automatic tend(input string s);
		$display("test %s done", s);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		results();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{rstn, ser_byte, ser_tx_data, ser_tx_en, ser_crc_clr, ser_byte_valid} = '0;
		{pwm_src, spc_src, enc_phase_a, enc_phase_b, encoder_index} = '0;
		{hall_signal_one, hall_signal_two, hall_signal_three, spc_frame_start, spc_nib_valid} = '0;
		{spc_nib, bist_done, bist_pass} = '0;
		{iface_pin_a_i, iface_pin_c_i} = 2'h3;
		n_fail = 0;
		n_checks = 0;
		fuse_interface_ab_config = 16'h0002;
		fuse_mode3 = 16'h0002;
		fuse_cal = 16'h5a3c;
		do_reset();
		wait_bit("bist_start", 0, 1'b1, 5);
		wait_bit("startup_done", 1, 1'b1, 30);
		chk("bist_fail", 16'h0001, {15'h0000, bist_fail});
		tend("selftest timeout");
		do_reset();
		wait_bit("bist_start", 0, 1'b1, 5);
		chk("pins before start", 16'h0015, pins());
		bist_done = 1'b1;
		bist_pass = 1'b1;
		wait_bit("startup_done", 1, 1'b1, 5);
		bist_done = 1'b0;
		chk("bist_fail", 16'h0000, {15'h0000, bist_fail});
		chk("pll_ref_ext", 16'h0000, {15'h0000, pll_ref_ext});
		chk("cal_word", 16'h5a3c, cal_word);
		// test paths follow the run state one cycle later
		step(1);
		chk("test_vec_en", 16'h0001, {15'h0000, test_vec_en});
		rdchk("interface_ab_config", `SSI_ADDR_INTERFACE_AB_CONFIG, 16'h0002);
		{hall_signal_one, hall_signal_two, hall_signal_three} = 3'b101;
		step(3);
		chk("hall pins", 16'h0022, pins());
		{hall_signal_one, hall_signal_two, hall_signal_three} = 3'b010;
		step(3);
		chk("hall pins", 16'h0008, pins());
		cfg(`SSI_ADDR_INTERFACE_AB_CONFIG, 16'h000a);
		chk("pll_ref_ext hall", 16'h0000, {15'h0000, pll_ref_ext});
		rdchk("interface_ab_config", `SSI_ADDR_INTERFACE_AB_CONFIG, 16'h000a);
		cfg(`SSI_ADDR_INTERFACE_AB_CONFIG, 16'h0006);
		chk("hall open drain", 16'h0004, pins());
		tend("hall");
		{enc_phase_a, enc_phase_b, encoder_index, hall_signal_one} = 4'b0111;
		cfg(`SSI_ADDR_INTERFACE_AB_CONFIG, 16'h0009);
		chk("enc pins", 16'h000a, pins());
		chk("pll_ref_ext enc", 16'h0000, {15'h0000, pll_ref_ext});
		tend("encoder");
		pwm_src = 1'b1;
		cfg(`SSI_ADDR_INTERFACE_AB_CONFIG, 16'h0008);
		chk("pwm pins", 16'h0025, pins() & 16'h0035);
		chk("pll_ref_ext pwm", 16'h0001, {15'h0000, pll_ref_ext});
		wait_bit("ext clk high", 2, 1'b1, 10);
		iface_pin_c_i = 1'b0;
		wait_bit("ext clk low", 2, 1'b0, 10);
		tend("pwm ext clock");
		cfg(`SSI_ADDR_INTERFACE_AB_CONFIG, 16'h0007);
		chk("spc od low", 16'h0005, pins());
		spc_src = 1'b1;
		step(3);
		chk("spc od high", 16'h0015, pins() | 16'h0010);
		chk("spc od release", 16'h0001, {15'h0000, iface_pin_a_oe_n});
		iface_pin_a_i = 1'b0;
		wait_bit("trigger", 3, 1'b1, 10);
		step(1);
		chk("trigger pulse", 16'h0000, {15'h0000, spc_trigger});
		cfg(`SSI_ADDR_INTERFACE_AB_CONFIG, 16'h000b);
		chk("pll_ref_ext spc", 16'h0001, {15'h0000, pll_ref_ext});
		tend("spc");
		ser_tx_en = 1'b1;
		ser_tx_data = 1'b1;
		step(2);
		chk("ser push-pull", 16'h0002, {14'h0000, data_line, serial_data_oe_n});
		cfg(`SSI_ADDR_MODE3, 16'h000f);
		chk("ser od release", 16'h0003, {14'h0000, data_line, serial_data_oe_n});
		ser_tx_data = 1'b0;
		step(2);
		chk("ser od low", 16'h0000, {14'h0000, data_line, serial_data_oe_n});
		chk("test paths", 16'h0007, {13'h0000, test_vec_en, stream_invert, stream_combine});
		rdchk("mode3", `SSI_ADDR_MODE3, 16'h000f);
		i_host.wr(8'h20, 16'hbeef);
		rdchk("unmapped", 8'h20, 16'h0000);
		tend("serial port");
		ser_crc_clr = 1'b1;
		ser_byte_valid = 1'b1;
		ser_byte = 8'h31;
		step(1);
		ser_crc_clr = 1'b0;
		step(1);
		ser_byte = 8'hc5;
		step(1);
		ser_byte_valid = 1'b0;
		chk("crc8", {8'h00, crc8(crc8(8'hff, 8'h31), 8'hc5)}, {8'h00, ser_crc});
		spc_frame_start = 1'b1;
		step(1);
		spc_frame_start = 1'b0;
		spc_nib_valid = 1'b1;
		spc_nib = 4'ha;
		step(1);
		spc_nib = 4'h3;
		step(1);
		spc_nib_valid = 1'b0;
		chk("crc4", {12'h000, crc4(crc4(4'h5, 4'ha), 4'h3)}, {12'h000, spc_crc});
		tend("checks");
		results();
	end
endmodule // tb
`default_nettype wire
